// file: core/sofc_defs.vh
`ifndef SOFC_DEFS_VH
`define SOFC_DEFS_VH

// register map and field layout of the output format control word
`define SOFC_ADDR_W 5
`define SOFC_DATA_W 11
`define SOFC_OFS_FMT 5'h0D
`define SOFC_RST_FMT 11'h000
// bits that hold a value; 3, 8 and 9 stay zero
`define SOFC_FMT_MASK 11'h4F7
`define SOFC_B_TWOWIRE 0
`define SOFC_B_SDR 1
`define SOFC_B_SER14 2
`define SOFC_B_RISEEDGE 4
`define SOFC_B_CGAIN 5
`define SOFC_B_LSBFIRST 6
`define SOFC_B_BITWISE 7
`define SOFC_B_OVRD 10
// pin input synchroniser depth
`define SOFC_SYNC_STAGES 2

`endif

// file: core/sofc_format_ctrl.v
// Local design decision: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "sofc_defs.vh"

// Contract
// - bit0 lanes, bit1 ddr/sdr, bit2 serialization
// - bit4 sdr capture edge, rising when set
// - bit5 enables 3.5 dB coarse gain
// - bit6 sends lsb first when set
// - bit7 bit-wise lane split, two-wire only
// - override bit10 lets register beat pins
// - hardware or software reset clears register
module sofc_format_ctrl
(
    input wire mclk, // system clock, 100 MHz
    input wire rst_n, // async reset, active low
    input wire swReset, // software reset pulse, same clock
    input wire [4:0] regAddr, // register address
    input wire [10:0] regWrData, // write data
    input wire regWrStb, // write strobe
    input wire regRdStb, // read strobe
    output reg [10:0] regRdData, // read data, cycle after strobe
    input wire pinTwoWire, // pin: two-wire lanes
    input wire pinSdrClk, // pin: sdr bit clock
    input wire pinSer14, // pin: 14x serialization
    input wire pinRiseEdge, // pin: rising capture edge
    input wire pinCoarseGain, // pin: coarse gain enable
    input wire pinLsbFirst, // pin: lsb first
    input wire pinBitWise, // pin: bit-wise split
    output reg twoWire, // lanes: 0 one-wire, 1 two-wire
    output reg sdrClk, // bit clock: 0 ddr, 1 sdr
    output reg ser14, // serialization: 0 12x, 1 14x
    output reg captureRising, // capture edge: 0 falling, 1 rising
    output reg coarseGainEn, // 1 applies 3.5 dB gain
    output reg lsbFirst, // bit order: 0 msb, 1 lsb first
    output reg bitWise, // lane split: 0 byte-wise, 1 bit-wise
    output reg pinOverride // register governs when high
);

    reg [10:0] fmt_reg;
    reg [10:0] fmt_next;
    wire [6:0] sel;
    wire wrHit;
    wire rdHit;
    wire laneTwo;
    wire clkSdr;
    genvar gi;
    wire [6:0] pinSync;
    wire [6:0] regFields;

    // pins come from outside the clock domain
    sofc_pin_sync uSync
    (
        .mclk(mclk),
        .rst_n(rst_n),
        .pinIn({pinBitWise, pinLsbFirst, pinCoarseGain, pinRiseEdge,
            pinSer14, pinSdrClk, pinTwoWire}),
        .pinSync(pinSync)
    );

    // address decode, shared by both strobes; only one word is mapped
    assign wrHit = regWrStb && (regAddr == `SOFC_OFS_FMT);
    assign rdHit = regRdStb && (regAddr == `SOFC_OFS_FMT);

    // write path; unused positions are masked off on the way in, and a
    // soft reset beats a write landing in the same cycle
    always @*
    begin
        fmt_next = fmt_reg;
        if (swReset)
            fmt_next = `SOFC_RST_FMT;
        else if (wrHit)
            fmt_next = regWrData & `SOFC_FMT_MASK;
    end

    // the stored word itself
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            fmt_reg <= `SOFC_RST_FMT;
        else
            fmt_reg <= fmt_next;
    end

    // read data valid only in the cycle after the strobe; a missed read
    // is not held over, the bus falls back to zero
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            regRdData <= 11'h000;
        else if (rdHit)
            regRdData <= fmt_reg;
        else
            regRdData <= 11'h000; // unmapped addresses read zero
    end

    // register fields lined up in pin order
    assign regFields = {fmt_reg[`SOFC_B_BITWISE], fmt_reg[`SOFC_B_LSBFIRST],
        fmt_reg[`SOFC_B_CGAIN], fmt_reg[`SOFC_B_RISEEDGE],
        fmt_reg[`SOFC_B_SER14], fmt_reg[`SOFC_B_SDR],
        fmt_reg[`SOFC_B_TWOWIRE]};

    // pins govern unless the override bit is set; one source switch
    // per field, all steered by the same stored override bit
    generate
        for (gi = 0; gi < 7; gi = gi + 1)
        begin : gSel
            assign sel[gi] = fmt_reg[`SOFC_B_OVRD] ? regFields[gi] :
                pinSync[gi];
        end
    endgenerate

    // mode qualifiers: the sdr clock and the lane split only mean
    // something on two lanes, the capture edge only under an sdr clock
    assign laneTwo = sel[0];
    assign clkSdr = sel[0] & sel[1];

    // effective settings, one flop each; registering them keeps a pin
    // edge or a write from reaching the serializer half-way through a
    // cycle, at the cost of one cycle of latency

    // lane count
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            twoWire <= 1'h0;
        end
        else
        begin
            twoWire <= laneTwo;
        end
    end

    // bit clock kind; only two lanes can run sdr, so one lane always
    // reports ddr
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sdrClk <= 1'h0;
        end
        else
        begin
            sdrClk <= clkSdr;
        end
    end

    // serialization factor
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ser14 <= 1'h0;
        end
        else
        begin
            ser14 <= sel[2];
        end
    end

    // capture edge; reads falling unless two lanes run an sdr clock,
    // so a receiver never waits on an edge that is not in use
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            captureRising <= 1'h0;
        end
        else
        begin
            captureRising <= clkSdr & sel[3];
        end
    end

    // coarse gain, 3.5 dB when set
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            coarseGainEn <= 1'h0;
        end
        else
        begin
            coarseGainEn <= sel[4];
        end
    end

    // bit order of each sample
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lsbFirst <= 1'h0;
        end
        else
        begin
            lsbFirst <= sel[5];
        end
    end

    // lane split; one lane has nothing to split, so it reads byte-wise
    // there while the stored bit is kept for a later switch
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bitWise <= 1'h0;
        end
        else
        begin
            bitWise <= laneTwo & sel[6];
        end
    end

    // copy of the override bit, so the source in use can be seen
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pinOverride <= 1'h0;
        end
        else
        begin
            pinOverride <= fmt_reg[`SOFC_B_OVRD];
        end
    end

endmodule // sofc_format_ctrl

`default_nettype wire

// file: core/sofc_pin_sync.v
`timescale 1ns/100ps
`default_nettype none

// two-stage synchroniser for the parallel configuration pins
module sofc_pin_sync
(
    input wire mclk, // system clock
    input wire rst_n, // async reset, active low
    input wire [6:0] pinIn, // raw pin levels
    output wire [6:0] pinSync // synchronised levels
);

    reg [6:0] meta_reg;
    reg [6:0] sync_reg;

    // first stage feeds only the second stage
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_reg <= 7'h00;
            sync_reg <= 7'h00;
        end
        else
        begin
            meta_reg <= pinIn;
            sync_reg <= meta_reg;
        end
    end

    assign pinSync = sync_reg;

endmodule // sofc_pin_sync

`default_nettype wire

// file: testbench/serial_output_format_config_bench.sv
`timescale 1ns/100ps
`default_nettype none
module serial_output_format_config_bench;
    logic mclk = 0, rst_n = 0, swReset = 0, regWrStb = 0, regRdStb = 0;
    logic [4:0] regAddr = 5'h00;
    logic [10:0] regWrData = 11'h000, fmt = 11'h000, rdExp, f;
    logic [6:0] pins = 7'h00, s1 = 7'h00, s2 = 7'h00;
    logic [7:0] oExp;
    logic [31:0] rnd = 32'hA9F4;
    wire [10:0] regRdData;
    wire [7:0] oSeen;
    int err_total = 0, cmp_count = 0, cyc = 0;
    sofc_format_ctrl uut (.mclk(mclk), .rst_n(rst_n), .swReset(swReset),
        .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
        .regRdStb(regRdStb), .regRdData(regRdData), .pinTwoWire(pins[0]),
        .pinSdrClk(pins[1]), .pinSer14(pins[2]), .pinRiseEdge(pins[3]),
        .pinCoarseGain(pins[4]), .pinLsbFirst(pins[5]),
        .pinBitWise(pins[6]), .twoWire(oSeen[0]), .sdrClk(oSeen[1]),
        .ser14(oSeen[2]), .captureRising(oSeen[3]), .coarseGainEn(oSeen[4]),
        .lsbFirst(oSeen[5]), .bitWise(oSeen[6]), .pinOverride(oSeen[7]));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic chk(input string n, input logic [10:0] s, e);
        cmp_count++;
        if (s !== e)
        begin
            err_total++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always #5 mclk = ~mclk;
    // hang guard, well above the 2000 test cycles
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            err_total++;
            end_sim();
        end
    end
    // model steps on the same edge as the design, then new stimulus
    initial
    begin
        rnd = 43508;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2000)
        begin
            @(posedge mclk);
            f = fmt[10] ? fmt : {3'h0, s2[6:3], 1'b0, s2[2:0]};
            oExp = {fmt[10], f[7] & f[0], f[6], f[5], f[4] & f[1] & f[0],
                f[2], f[1] & f[0], f[0]};
            rdExp = (regRdStb && regAddr == 5'h0D) ? fmt : 11'h000;
            if (!rst_n || swReset)
                fmt = 11'h000;
            else if (regWrStb && regAddr == 5'h0D)
                fmt = regWrData & 11'h4F7;
            s2 = rst_n ? s1 : 7'h00;
            s1 = rst_n ? pins : 7'h00;
            rnd = xs(rnd);
            // strobes exclusive; unmapped addresses mixed in
            regWrStb <= rnd[1:0] == 2'h0;
            regRdStb <= rnd[1:0] == 2'h1;
            regAddr <= rnd[2] ? 5'h0D : rnd[7:3];
            regWrData <= rnd[18:8];
            swReset <= rnd[24:19] == 6'h00;
            rst_n <= (cyc != 1000); // one hardware reset mid-run
            if (rnd[8] & rnd[3])
                pins <= rnd[31:25];
            #1;
            // a reset pulse clears the design at once, not at the next edge
            if (!rst_n)
            begin
                fmt = 11'h000;
                s1 = 7'h00;
                s2 = 7'h00;
                oExp = 8'h00;
                rdExp = 11'h000;
            end
            chk("outputs", {3'h0, oSeen}, {3'h0, oExp});
            chk("rddata", regRdData, rdExp);
        end
        end_sim();
    end
endmodule // serial_output_format_config_bench
`default_nettype wire

// file: testbench/sofc_props.sv
`timescale 1ns/100ps
`default_nettype none
module sofc_props
(
    input wire logic mclk, rst_n, swReset, regWrStb, // control
    input wire logic [4:0] regAddr, // address
    input wire logic [10:0] regWrData, regRdData, // data
    input wire logic pinLsbFirst, twoWire, sdrClk, ser14, // pins, lanes
    input wire logic captureRising, coarseGainEn, lsbFirst, bitWise,
    input wire logic pinOverride // override copy
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // override write with a quiet cycle after it, so nothing masks it
    sequence wrOv;
        regWrStb && regAddr == 5'h0D && regWrData[10] && !swReset
        ##1 !regWrStb && !swReset;
    endsequence
    chk_sdr_gate: assert property (sdrClk |-> twoWire)
        else $error("sdr clock outside two-wire");
    chk_edge_gate: assert property (captureRising |-> sdrClk)
        else $error("capture edge outside sdr");
    chk_gain_write: assert property (wrOv |=>
        coarseGainEn == $past(regWrData[5], 2))
        else $error("gain not taken from write");
    chk_order_write: assert property (wrOv |=>
        lsbFirst == $past(regWrData[6], 2) && pinOverride)
        else $error("bit order not taken from write");
    chk_split_gate: assert property (bitWise |-> twoWire)
        else $error("bit-wise split outside two-wire");
    // sync flops are reset, so only judge after three live edges
    chk_pin_follow: assert property (!pinOverride && $past(rst_n, 3)
        && $past(rst_n, 2) && $past(rst_n) |->
        lsbFirst == $past(pinLsbFirst, 3))
        else $error("pins not followed");
    chk_sw_clear: assert property (swReset ##1 !regWrStb |=>
        !pinOverride)
        else $error("soft reset left override set");
    chk_rd_unused: assert property ((regRdData & 11'h308) == 11'h000)
        else $error("unused bit read as one");
    cover property (wrOv);
    cover property (swReset ##2 !pinOverride);
    cover property (captureRising && bitWise && ser14);
endmodule // sofc_props
bind sofc_format_ctrl sofc_props props (.mclk, .rst_n, .swReset,
    .regWrStb, .regAddr, .regWrData, .regRdData, .pinLsbFirst, .twoWire,
    .sdrClk, .ser14, .captureRising, .coarseGainEn, .lsbFirst, .bitWise,
    .pinOverride);
`default_nettype wire
